//--- common/timer_pkg.sv
// constants, register map and modes of the general purpose timer core
// ***********************************************************************
// Overview of operation
// - with slave controller off, the prescaler runs from the kernel clock.
// - external clock mode 1 counts filtered, polarity-set channel 1..4 edges.
// - channel 1 both-edge pulse is a selectable trigger.
// - external trigger pin passes polarity, divider and filter into trigger select.
// - internal trigger is unfiltered and may reset, start, stop or clock us.
// - counter and reload are 16 or 32 bits wide per instance.
// - up mode counts from 0, wraps to 0 after reload, flags overflow.
// - overflow or underflow makes an update loading reload and divider shadows.
// - update disable suppresses update events and shadow loads.
// - down mode counts from reload, reloads after 0, flags underflow.
// - center mode counts 0 to reload and back, events at reload-1 and 1.
// - control register bits select up, down or center counting.
// - 16-bit divider divides the counter clock by 1 to 65536.
// - divider value is buffered and takes effect at the next update.
// - four independent capture/compare channels each own a match register.
// - capture input is filtered, edge detected and latches the count.
// - capture prescaler sets events needed per capture.
// - capture sets the channel flag and requests interrupt when enabled.
// - eight compare output modes are selected by the mode field.
// - on match the output goes high, low or toggles per mode and polarity.
// - set compare flag requests interrupt if enabled, DMA if selected.
// - PWM width follows match value, period follows reload, all count modes.
// - PWM mode 1 is active while count is below match value.
// - PWM mode 2 is inactive while count is below match value.
// - tick rate is prescaler input rate over divider value plus one.
// - mode codes 100 and 101 force reference inactive and active.
// ***********************************************************************
package timer_pkg;
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_SLAVE = 8'h08;
	localparam logic [7:0] OFS_IEN = 8'h0c;
	localparam logic [7:0] OFS_STS = 8'h10;
	localparam logic [7:0] OFS_EVGEN = 8'h14;
	localparam logic [7:0] OFS_CHMODE = 8'h18;
	localparam logic [7:0] OFS_COUNT = 8'h24;
	localparam logic [7:0] OFS_DIV = 8'h28;
	localparam logic [7:0] OFS_RELOAD = 8'h2c;
	localparam logic [7:0] OFS_MATCH0 = 8'h34;
	localparam int CTRL1_EN = 0;
	localparam int CTRL1_UD = 1;
	localparam int CTRL1_DIR = 2;
	localparam int CH_OMODE = 0;
	localparam int CH_INPUT = 3;
	localparam int CH_CAPDIV = 4;
	localparam int CH_POL = 6;
	localparam int SLV_FUNC = 0;
	localparam int SLV_TSEL = 4;
	localparam int SLV_EPOL = 7;
	localparam int SLV_EDIV = 8;
	localparam int SLV_FLEN = 12;
	localparam int STS_UPD = 4;
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [31:0] RELOAD_RST = 32'hffffffff;
	typedef enum logic [1:0] {
		CNT_UP = 2'b00, CNT_DOWN = 2'b01, CNT_CENTER = 2'b10
	} count_mode_t;
	typedef enum logic [2:0] {
		SLV_OFF = 3'b000, SLV_CLOCK = 3'b001, SLV_RESET = 3'b010,
		SLV_GATED = 3'b011, SLV_TRIG = 3'b100
	} slave_func_t;
	typedef enum logic [2:0] {
		OM_FREEZE = 3'b000, OM_SET = 3'b001, OM_CLR = 3'b010,
		OM_TOGGLE = 3'b011, OM_FORCE_LO = 3'b100, OM_FORCE_HI = 3'b101,
		OM_PWM1 = 3'b110, OM_PWM2 = 3'b111
	} out_mode_t;
	localparam logic [2:0] TSEL_EDGE1 = 3'h4;
	localparam logic [2:0] TSEL_EXT = 3'h5;
	localparam logic [2:0] TSEL_ITR = 3'h6;
endpackage : timer_pkg

//--- common/cond_if.sv
// conditioned input signal carried from the input stage to the core
`timescale 1ns/1ns
interface cond_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, rise, fall);
	modport dst (input level, rise, fall);
endinterface : cond_if

//--- rtl/sig_cond.sv
// input stage: synchroniser, polarity, edge divider, filter, edge pulses
`timescale 1ns/1ns
module sig_cond #(
	parameter int FILT_W = 4
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic pin,
	input wire logic invert,
	input wire logic [1:0] div_sel,
	input wire logic [FILT_W-1:0] filt_len,
	cond_if.src out
);
	initial begin
		if (FILT_W < 1 || FILT_W > 8) $error("sig_cond: bad FILT_W");
	end
	logic s1_reg, s2_reg, pol_q_reg, filt_reg;
	logic [2:0] ecnt_reg;
	logic [FILT_W-1:0] stab_reg;
	wire pol = s2_reg ^ invert;
	wire pol_rise = pol & ~pol_q_reg;
	// dividing by edge count keeps the duty of slow inputs irrelevant
	wire divided = (div_sel == 2'd0) ? pol : ecnt_reg[div_sel - 2'd1];
	wire differs = divided != filt_reg;
	wire settle = differs && (stab_reg >= filt_len);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			pol_q_reg <= 1'b0;
			ecnt_reg <= 3'd0;
			stab_reg <= '0;
			filt_reg <= 1'b0;
			out.level <= 1'b0;
			out.rise <= 1'b0;
			out.fall <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			pol_q_reg <= pol;
			if (pol_rise) ecnt_reg <= ecnt_reg + 3'd1;
			stab_reg <= (differs && !settle) ? stab_reg + 1'b1 : '0;
			if (settle) filt_reg <= divided;
			out.level <= filt_reg;
			out.rise <= settle & divided;
			out.fall <= settle & ~divided;
		end
	end
endmodule : sig_cond

//--- rtl/gp_timer.sv
// general purpose timer core with Avalon-MM register slave
`timescale 1ns/1ns
module gp_timer import timer_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] ch_pin,
	input wire logic ext_trigger_pin,
	input wire logic itr_in,
	output logic [3:0] cmp_out,
	output logic irq_req,
	output logic dma_req
);
	initial begin
		if (CNT_W != 16 && CNT_W != 32) $error("gp_timer: CNT_W 16 or 32");
	end
	// ***************************************************************
	// register bus
	// ***************************************************************
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic en_reg, ud_reg, dmasel_reg, ugen_reg, moved_reg, itr_q_reg;
	logic [1:0] mode_reg;
	logic [15:0] slave_reg;
	logic [7:0] ien_reg;
	logic [4:0] sts_reg;
	logic [31:0] chm_reg;
	logic [15:0] psc_reg, psc_sh_reg, pcnt_reg;
	logic [CNT_W-1:0] cnt_reg, arr_reg, arr_sh_reg;
	logic dn_reg;
	logic [CNT_W-1:0] ccr_reg [4];
	logic [2:0] evc_reg [4];
	logic [3:0] ref_reg, out_reg;
	logic irq_reg, dma_reg;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
		end
		return r;
	endfunction : merge

	// a write takes effect only at the edge where waitrequest is low
	wire wr = avs_write & ~wait_reg;
	wire [31:0] wd = merge(32'h0, avs_writedata, avs_byteenable);
	wire wr_ctrl1 = wr && avs_address == OFS_CTRL1;
	wire wr_ctrl2 = wr && avs_address == OFS_CTRL2;
	wire wr_slave = wr && avs_address == OFS_SLAVE;
	wire wr_ien = wr && avs_address == OFS_IEN;
	wire wr_sts = wr && avs_address == OFS_STS;
	wire wr_evgen = wr && avs_address == OFS_EVGEN;
	wire wr_chm = wr && avs_address == OFS_CHMODE;
	wire wr_cnt = wr && avs_address == OFS_COUNT;
	wire wr_div = wr && avs_address == OFS_DIV;
	wire wr_arr = wr && avs_address == OFS_RELOAD;
	wire [5:0] ch_word = 6'(avs_address[7:2] - OFS_MATCH0[7:2]);
	wire wr_ccr_any = wr && avs_address >= OFS_MATCH0 && ch_word < 6'd4;
	wire [31:0] cnt32 = 32'(cnt_reg);
	wire [31:0] arr32 = 32'(arr_reg);
	wire [31:0] ccr32 = (ch_word < 6'd4) ? 32'(ccr_reg[ch_word[1:0]]) : '0;
	wire [31:0] rd_mux =
		(avs_address == OFS_CTRL1) ? {28'h0, mode_reg, ud_reg, en_reg} :
		(avs_address == OFS_CTRL2) ? {31'h0, dmasel_reg} :
		(avs_address == OFS_SLAVE) ? {16'h0, slave_reg} :
		(avs_address == OFS_IEN) ? {24'h0, ien_reg} :
		(avs_address == OFS_STS) ? {27'h0, sts_reg} :
		(avs_address == OFS_CHMODE) ? chm_reg :
		(avs_address == OFS_COUNT) ? cnt32 :
		(avs_address == OFS_DIV) ? {16'h0, psc_reg} :
		(avs_address == OFS_RELOAD) ? arr32 :
		(avs_address >= OFS_MATCH0) ? ccr32 : 32'h0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0;
		end else begin
			wait_reg <= ~((avs_read | avs_write) & wait_reg);
			if (avs_read & wait_reg) rdata_reg <= rd_mux;
		end
	end
	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;

	// ***************************************************************
	// input conditioning and trigger selection
	// ***************************************************************
	wire [2:0] sfun = slave_reg[SLV_FUNC +: 3];
	wire [2:0] tsel = slave_reg[SLV_TSEL +: 3];
	wire [3:0] flen = slave_reg[SLV_FLEN +: 4];
	logic [4:0] c_lvl, c_rise, c_fall;
	wire [4:0] pins = {ext_trigger_pin, ch_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_in
			cond_if c_if ();
			wire inv = (gi == 4) ? slave_reg[SLV_EPOL] :
				chm_reg[8*(gi%4) + CH_POL];
			wire [1:0] dsel = (gi == 4) ? slave_reg[SLV_EDIV +: 2] : 2'd0;
			sig_cond #(.FILT_W(4)) u_cond (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.pin(pins[gi]),
				.invert(inv),
				.div_sel(dsel),
				.filt_len(flen),
				.out(c_if.src)
			);
			assign c_lvl[gi] = c_if.level;
			assign c_rise[gi] = c_if.rise;
			assign c_fall[gi] = c_if.fall;
		end
	endgenerate

	wire ch1_both_edge_pulse = c_rise[0] | c_fall[0];
	wire itr_rise = itr_in & ~itr_q_reg;
	wire slave_trigger_select_in =
		(tsel < TSEL_EDGE1) ? c_lvl[tsel[1:0]] :
		(tsel == TSEL_EDGE1) ? ch1_both_edge_pulse :
		(tsel == TSEL_EXT) ? c_lvl[4] : itr_in;
	wire trig_rise =
		(tsel < TSEL_EDGE1) ? c_rise[tsel[1:0]] :
		(tsel == TSEL_EDGE1) ? ch1_both_edge_pulse :
		(tsel == TSEL_EXT) ? c_rise[4] : itr_rise;

	// ***************************************************************
	// clock source, prescaler and time base
	// ***************************************************************
	// one source only is ever selected; clock mode passes edge pulses,
	// gated mode the trigger level and every other mode a constant 1
	wire prescaler_input_clock =
		(sfun == SLV_CLOCK) ? trig_rise :
		(sfun == SLV_GATED) ? slave_trigger_select_in : 1'b1;
	wire slave_reinit = (sfun == SLV_RESET) && trig_rise;
	wire reinit = ugen_reg | slave_reinit;
	wire run = en_reg && arr_sh_reg != '0;
	wire psc_hit = pcnt_reg == psc_sh_reg;
	// tick rate is the input rate over divider+1
	wire counter_tick_clock = run & prescaler_input_clock & psc_hit;
	wire [CNT_W-1:0] arr_m1 = arr_sh_reg - 1'b1;

	logic [CNT_W-1:0] cnt_next;
	logic dn_next, wrap_evt;
	always_comb begin
		cnt_next = cnt_reg;
		dn_next = dn_reg;
		wrap_evt = 1'b0;
		case (count_mode_t'(mode_reg))
			CNT_UP: begin
				wrap_evt = cnt_reg == arr_sh_reg;
				cnt_next = wrap_evt ? '0 : cnt_reg + 1'b1;
			end
			CNT_DOWN: begin
				wrap_evt = cnt_reg == '0;
				cnt_next = wrap_evt ? arr_sh_reg : cnt_reg - 1'b1;
			end
			CNT_CENTER: begin
				if (!dn_reg) begin
					wrap_evt = cnt_reg == arr_m1;
					dn_next = cnt_reg >= arr_m1;
					cnt_next = (cnt_reg >= arr_sh_reg) ? arr_m1 : cnt_reg + 1'b1;
				end else begin
					wrap_evt = cnt_reg == CNT_W'(1);
					dn_next = cnt_reg > CNT_W'(1);
					cnt_next = (cnt_reg == '0) ? CNT_W'(1) : cnt_reg - 1'b1;
				end
			end
			default: begin
				cnt_next = cnt_reg;
			end
		endcase
	end

	wire uev = (reinit | (counter_tick_clock & wrap_evt)) & ~ud_reg;
	wire [CNT_W-1:0] init_val = (mode_reg == CNT_DOWN) ? arr_sh_reg : '0;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcnt_reg <= 16'h0;
			psc_sh_reg <= DIV_RST;
			arr_sh_reg <= CNT_W'(RELOAD_RST);
			cnt_reg <= '0;
			dn_reg <= 1'b0;
			moved_reg <= 1'b0;
			itr_q_reg <= 1'b0;
		end else begin
			itr_q_reg <= itr_in;
			moved_reg <= counter_tick_clock;
			if (uev || reinit) pcnt_reg <= 16'h0;
			else if (run && prescaler_input_clock)
				pcnt_reg <= psc_hit ? 16'h0 : pcnt_reg + 16'h1;
			if (uev) begin
				psc_sh_reg <= psc_reg;
				arr_sh_reg <= arr_reg;
			end
			if (wr_cnt) cnt_reg <= wd[CNT_W-1:0];
			else if (reinit) cnt_reg <= init_val;
			else if (counter_tick_clock) cnt_reg <= cnt_next;
			if (reinit) dn_reg <= 1'b0;
			else if (counter_tick_clock) dn_reg <= dn_next;
		end
	end

	// ***************************************************************
	// control registers and status flags
	// ***************************************************************
	logic [3:0] cap_set, cmp_set;
	wire [4:0] set_bits = {uev, cap_set | cmp_set};
	wire [4:0] keep = wr_sts ? wd[4:0] : 5'h1f;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_reg <= 1'b0;
			ud_reg <= 1'b0;
			mode_reg <= CNT_UP;
			dmasel_reg <= 1'b0;
			slave_reg <= 16'h0;
			ien_reg <= 8'h0;
			sts_reg <= 5'h0;
			chm_reg <= 32'h0;
			psc_reg <= DIV_RST;
			arr_reg <= CNT_W'(RELOAD_RST);
			ugen_reg <= 1'b0;
			irq_reg <= 1'b0;
			dma_reg <= 1'b0;
		end else begin
			if (wr_ctrl1) begin
				en_reg <= wd[CTRL1_EN];
				ud_reg <= wd[CTRL1_UD];
				mode_reg <= wd[CTRL1_DIR +: 2];
			end else if (sfun == SLV_TRIG && trig_rise) begin
				en_reg <= 1'b1;
			end
			if (wr_ctrl2) dmasel_reg <= wd[0];
			if (wr_slave) slave_reg <= wd[15:0];
			if (wr_ien) ien_reg <= wd[7:0];
			if (wr_chm) chm_reg <= merge(chm_reg, avs_writedata, avs_byteenable);
			if (wr_div) psc_reg <= wd[15:0];
			if (wr_arr) arr_reg <= wd[CNT_W-1:0];
			ugen_reg <= wr_evgen & wd[0];
			// write zero clears; a same-cycle event still sets
			sts_reg <= (sts_reg & keep) | set_bits;
			irq_reg <= |(sts_reg[3:0] & ien_reg[3:0]);
			dma_reg <= dmasel_reg & |(sts_reg[3:0] & ien_reg[7:4]);
		end
	end
	assign irq_req = irq_reg;
	assign dma_req = dma_reg;

	// ***************************************************************
	// capture/compare channels
	// ***************************************************************
	logic [3:0] cap_hit;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			wire [7:0] cm = chm_reg[8*gi +: 8];
			wire is_in = cm[CH_INPUT];
			wire [2:0] need = 3'((1 << cm[CH_CAPDIV +: 2]) - 1);
			wire hit = cnt_reg == ccr_reg[gi];
			assign cap_hit[gi] = is_in & c_rise[gi] & (evc_reg[gi] == need);
			assign cap_set[gi] = cap_hit[gi];
			assign cmp_set[gi] = ~is_in & moved_reg & hit;
			logic ref_next;
			always_comb begin
				case (out_mode_t'(cm[CH_OMODE +: 3]))
					OM_FREEZE: ref_next = ref_reg[gi];
					OM_SET: ref_next = ref_reg[gi] | cmp_set[gi];
					OM_CLR: ref_next = ref_reg[gi] & ~cmp_set[gi];
					OM_TOGGLE: ref_next = ref_reg[gi] ^ cmp_set[gi];
					OM_FORCE_LO: ref_next = 1'b0;
					OM_FORCE_HI: ref_next = 1'b1;
					// width from match value, period from reload shadow
					OM_PWM1: ref_next = cnt_reg < ccr_reg[gi];
					OM_PWM2: ref_next = !(cnt_reg < ccr_reg[gi]);
					default: ref_next = 1'b0;
				endcase
			end
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					ccr_reg[gi] <= '0;
					evc_reg[gi] <= 3'd0;
					ref_reg[gi] <= 1'b0;
					out_reg[gi] <= 1'b0;
				end else begin
					if (is_in && c_rise[gi])
						evc_reg[gi] <= cap_hit[gi] ? 3'd0 : evc_reg[gi] + 3'd1;
					if (cap_hit[gi]) ccr_reg[gi] <= cnt_reg;
					else if (wr_ccr_any && ch_word[1:0] == 2'(gi))
						ccr_reg[gi] <= wd[CNT_W-1:0];
					ref_reg[gi] <= is_in ? 1'b0 : ref_next;
					out_reg[gi] <= ref_next ^ cm[CH_POL];
				end
			end
		end
	endgenerate
	assign cmp_out = out_reg;

	// ***************************************************************
	// checks
	// ***************************************************************
	wire quiet = !wr_cnt && !reinit;
	wire [2:0] om0 = chm_reg[CH_OMODE +: 3];
	sequence s_force_lo;
		!chm_reg[CH_INPUT] && om0 == OM_FORCE_LO;
	endsequence
	property p_arr_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!uev |=> $stable(arr_sh_reg);
	endproperty
	a_arr_hold: assert property (p_arr_hold)
		else $error("reload shadow moved without update");
	property p_psc_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!uev |=> psc_sh_reg == $past(psc_sh_reg);
	endproperty
	a_psc_hold: assert property (p_psc_hold)
		else $error("divider shadow moved without update");
	property p_ud_block;
		@(posedge ref_clk) disable iff (sys_rst)
		ud_reg && wr_div |=> ##1 psc_sh_reg == $past(psc_sh_reg, 2);
	endproperty
	a_ud_block: assert property (p_ud_block)
		else $error("update passed while disabled");
	property p_up_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		counter_tick_clock && quiet && mode_reg == CNT_UP &&
		cnt_reg == arr_sh_reg |=> cnt_reg == '0 && sts_reg[STS_UPD] ||
		$past(ud_reg);
	endproperty
	a_up_wrap: assert property (p_up_wrap)
		else $error("up count did not wrap to zero");
	property p_down_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		counter_tick_clock && quiet && mode_reg == CNT_DOWN &&
		cnt_reg == '0 |=> cnt_reg == $past(arr_sh_reg);
	endproperty
	a_down_wrap: assert property (p_down_wrap)
		else $error("down count did not reload");
	property p_capture;
		@(posedge ref_clk) disable iff (sys_rst)
		cap_hit[0] |=> ccr_reg[0] == $past(cnt_reg) && sts_reg[0];
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value or flag missing");
	property p_force;
		@(posedge ref_clk) disable iff (sys_rst)
		s_force_lo ##1 s_force_lo |-> ref_reg[0] == 1'b0;
	endproperty
	a_force: assert property (p_force)
		else $error("forced inactive not held");
	property p_pwm1;
		@(posedge ref_clk) disable iff (sys_rst)
		!chm_reg[CH_INPUT] && om0 == OM_PWM1 |=>
		ref_reg[0] == ($past(cnt_reg) < $past(ccr_reg[0]));
	endproperty
	a_pwm1: assert property (p_pwm1)
		else $error("pwm mode 1 level wrong");
	property p_tick_rate;
		@(posedge ref_clk) disable iff (sys_rst)
		counter_tick_clock && sfun == SLV_OFF && psc_sh_reg == 16'h1 &&
		!uev |=> !counter_tick_clock;
	endproperty
	a_tick_rate: assert property (p_tick_rate)
		else $error("tick faster than divider allows");
endmodule : gp_timer

//--- tb/ext_pins.sv
// partner model: channel pins, external trigger pin and a master timer
`timescale 1ns/1ns
module ext_pins (
	input wire logic ref_clk,
	output logic [3:0] ch_pin,
	output logic ext_trigger_pin,
	output logic itr_in
);
	initial begin
		ch_pin = 4'h0;
		ext_trigger_pin = 1'b0;
		itr_in = 1'b0;
	end

	// ***********************************************************
	// pulse trains
	// ***********************************************************
	// slow levels so that synchroniser and filter pass every edge;
	// sources 0..4 are channel pins (4 is channel 1 for both edges),
	// 5 the external trigger pin, 6 the master timer trigger
	task automatic pulse(input int src, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			if (src == 5) ext_trigger_pin <= ~ext_trigger_pin;
			else if (src == 6) itr_in <= ~itr_in;
			else ch_pin[src % 4] <= ~ch_pin[src % 4];
			repeat (10) @(posedge ref_clk);
		end
	endtask : pulse
endmodule : ext_pins

//--- tb/tb_top.sv
// self-checking testbench of the general purpose timer core
`timescale 1ns/1ns
module tb_top import timer_pkg::*;;
	logic ref_clk;
	logic sys_rst;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] ch_pin;
	logic ext_trigger_pin;
	logic itr_in;
	logic [3:0] cmp_out;
	logic irq_req;
	logic dma_req;
	int mismatches = 0;
	int checks_done = 0;
	logic [31:0] q;
	logic [31:0] q2;
	logic [31:0] hi;
	logic [31:0] rises;

	gp_timer #(.CNT_W(16)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ch_pin(ch_pin),
		.ext_trigger_pin(ext_trigger_pin), .itr_in(itr_in),
		.cmp_out(cmp_out), .irq_req(irq_req), .dma_req(dma_req));
	ext_pins pins (.ref_clk(ref_clk), .ch_pin(ch_pin),
		.ext_trigger_pin(ext_trigger_pin), .itr_in(itr_in));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic acc(input logic [7:0] a, input logic [31:0] d,
		input logic w, output logic [31:0] r);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		r = avs_readdata;
		check({31'h0, avs_waitrequest}, 32'h0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(a, d, 1'b1, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		acc(a, 32'h0, 1'b0, r);
	endtask : rd
	task automatic measure(input int ch, input int len);
		logic prev;
		prev = cmp_out[ch];
		hi = 32'h0;
		rises = 32'h0;
		for (int i = 0; i < len; i++) begin
			@(posedge ref_clk);
			if (cmp_out[ch] === 1'b1) hi++;
			if (cmp_out[ch] === 1'b1 && prev === 1'b0) rises++;
			prev = cmp_out[ch];
		end
	endtask : measure
	task automatic conclude;
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	// ***********************************************************
	// scenarios
	// ***********************************************************
	task automatic t_reset;
		rd(OFS_RELOAD, q);
		check(q, 32'h0000ffff);
		rd(OFS_DIV, q);
		check(q, 32'h0);
		wr(8'hfc, 32'h000000a5);
		rd(8'hfc, q);
		check(q, 32'h0);
		$display("done: reset");
	endtask : t_reset
	// two back-to-back reads sample the count exactly three clocks apart
	task automatic t_direction;
		wr(OFS_RELOAD, 32'hff);
		wr(OFS_EVGEN, 32'h1);
		wr(OFS_CTRL1, 32'h1);
		rd(OFS_COUNT, q);
		rd(OFS_COUNT, q2);
		check((q2 - q) & 32'hff, 32'h3);
		wr(OFS_CTRL1, 32'h5);
		rd(OFS_COUNT, q);
		rd(OFS_COUNT, q2);
		check((q - q2) & 32'hff, 32'h3);
		wr(OFS_CTRL1, 32'h1);
		wr(OFS_DIV, 32'h1);
		wr(OFS_EVGEN, 32'h1);
		rd(OFS_COUNT, q);
		rd(OFS_COUNT, q2);
		check((q2 - q) & 32'hff, 32'h1);
		$display("done: direction");
	endtask : t_direction
	task automatic t_pwm;
		wr(OFS_RELOAD, 32'h7);
		wr(OFS_MATCH0, 32'h5);
		wr(OFS_DIV, 32'h0);
		wr(OFS_CHMODE, {29'h0, OM_PWM1});
		wr(OFS_EVGEN, 32'h1);
		repeat (24) @(posedge ref_clk);
		measure(0, 64);
		check(hi, 32'h28);
		check(rises, 32'h8);
		wr(OFS_CHMODE, {29'h0, OM_PWM2});
		measure(0, 64);
		check(hi, 32'h18);
		wr(OFS_CHMODE, {29'h0, OM_PWM1});
		wr(OFS_CTRL1, 32'h5);
		measure(0, 64);
		check(hi, 32'h28);
		wr(OFS_CTRL1, 32'h9);
		repeat (16) @(posedge ref_clk);
		measure(0, 56);
		check(hi, 32'h24);
		check(rises, 32'h4);
		$display("done: pwm");
	endtask : t_pwm
	task automatic t_update_disable;
		wr(OFS_CTRL1, 32'h1);
		wr(OFS_MATCH0, 32'h2);
		wr(OFS_CTRL1, 32'h3);
		wr(OFS_RELOAD, 32'h3);
		wr(OFS_DIV, 32'h1);
		wr(OFS_STS, 32'h0);
		repeat (16) @(posedge ref_clk);
		measure(0, 64);
		check(hi, 32'h10);
		check(rises, 32'h8);
		rd(OFS_STS, q);
		check(q & 32'h10, 32'h0);
		wr(OFS_CTRL1, 32'h1);
		repeat (40) @(posedge ref_clk);
		measure(0, 64);
		check(hi, 32'h20);
		check(rises, 32'h8);
		rd(OFS_STS, q);
		check(q & 32'h10, 32'h10);
		$display("done: update disable");
	endtask : t_update_disable
	task automatic t_modes;
		logic [2:0] pre [4] = '{OM_FORCE_LO, OM_FORCE_HI, OM_FORCE_HI,
			OM_FORCE_LO};
		logic [2:0] md [4] = '{OM_SET, OM_CLR, OM_FREEZE, OM_TOGGLE};
		logic [31:0] ex [4] = '{32'h40, 32'h0, 32'h40, 32'h20};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CHMODE, {29'h0, pre[i]});
			repeat (8) @(posedge ref_clk);
			check({31'h0, cmp_out[0]}, {31'h0, pre[i][0]});
			wr(OFS_CHMODE, {29'h0, md[i]});
			repeat (16) @(posedge ref_clk);
			measure(0, 64);
			check(hi, ex[i]);
		end
		wr(OFS_CHMODE, 32'h45);
		repeat (8) @(posedge ref_clk);
		check({31'h0, cmp_out[0]}, 32'h0);
		wr(OFS_CHMODE, 32'h05050505);
		repeat (8) @(posedge ref_clk);
		check({28'h0, cmp_out}, 32'hf);
		$display("done: modes");
	endtask : t_modes
	task automatic t_flags;
		wr(OFS_CHMODE, {29'h0, OM_PWM1});
		wr(OFS_STS, 32'h0);
		wr(OFS_IEN, 32'h11);
		wr(OFS_CTRL2, 32'h1);
		repeat (16) @(posedge ref_clk);
		check({30'h0, irq_req, dma_req}, 32'h3);
		wr(OFS_CTRL2, 32'h0);
		repeat (4) @(posedge ref_clk);
		check({31'h0, dma_req}, 32'h0);
		wr(OFS_IEN, 32'h0);
		repeat (4) @(posedge ref_clk);
		check({31'h0, irq_req}, 32'h0);
		$display("done: flags");
	endtask : t_flags
	task automatic t_capture;
		wr(OFS_CTRL1, 32'h0);
		wr(OFS_COUNT, 32'h3);
		wr(OFS_CHMODE, 32'h1800);
		wr(OFS_STS, 32'h0);
		wr(OFS_IEN, 32'h2);
		pins.pulse(1, 1);
		rd(OFS_STS, q);
		check(q & 32'h2, 32'h0);
		check({31'h0, irq_req}, 32'h0);
		pins.pulse(1, 1);
		rd(OFS_STS, q);
		check(q & 32'h2, 32'h2);
		check({31'h0, irq_req}, 32'h1);
		rd(OFS_MATCH0 + 8'h4, q);
		check(q, 32'h3);
		$display("done: capture");
	endtask : t_capture
	task automatic t_triggers;
		wr(OFS_IEN, 32'h0);
		wr(OFS_CHMODE, 32'h0);
		wr(OFS_RELOAD, 32'hffff);
		wr(OFS_DIV, 32'h0);
		wr(OFS_EVGEN, 32'h1);
		wr(OFS_CTRL1, 32'h1);
		for (int t = 0; t < 7; t++) begin
			wr(OFS_SLAVE, {25'h0, 3'(t), 4'h1});
			wr(OFS_COUNT, 32'h0);
			pins.pulse(t, 3);
			rd(OFS_COUNT, q);
			check(q, (t == 4) ? 32'h6 : 32'h3);
		end
		// reset mode: a master edge pulls a large count back near zero
		wr(OFS_COUNT, 32'h1000);
		wr(OFS_SLAVE, 32'h62);
		pins.pulse(6, 1);
		rd(OFS_COUNT, q);
		check({31'h0, q < 32'h40}, 32'h1);
		// trigger mode: a master edge starts a stopped counter
		wr(OFS_CTRL1, 32'h0);
		wr(OFS_SLAVE, 32'h64);
		pins.pulse(6, 1);
		rd(OFS_CTRL1, q);
		check(q & 32'h1, 32'h1);
		$display("done: triggers");
	endtask : t_triggers

	// ***********************************************************
	// main sequence and watchdog
	// ***********************************************************
	initial begin
		sys_rst = 1'b1;
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_direction();
		t_pwm();
		t_update_disable();
		t_modes();
		t_flags();
		t_capture();
		t_triggers();
		conclude();
	end
	// the whole run needs well under 10000 clocks
	initial begin
		repeat (30000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end
endmodule : tb_top
